// [core/pscp_core.sv]
// Serial command port: shifter, decoder, display latches, APB slave
`timescale 1ns/100ps
module pscp_core #(
  parameter int BLANK_CYC = pscp_pkg::BLANK_WIN_CYC, // Window timeout
  parameter int SCAN_LEN = pscp_pkg::SCAN_CYC // Key scan length
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk_in,
  input wire logic load_in,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe,
  input wire logic blank_in,
  output logic [pscp_pkg::SEG_BITS-1:0] seg_a_out,
  output logic [pscp_pkg::SEG_BITS-1:0] seg_b_out,
  output logic led_bit,
  output logic lcd_on,
  output logic scan_done
);
  import pscp_pkg::*;

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  // Counter widths below bound what these parameters may be
  if (BLANK_CYC < 1 || BLANK_CYC > 8191) begin : g_bad_blank
    $error("BLANK_CYC must be 1 to 8191");
  end
  if (SCAN_LEN < 1 || SCAN_LEN > 255) begin : g_bad_scan
    $error("SCAN_LEN must be 1 to 255");
  end

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // True when the code loads a display frame
  function automatic logic is_disp(input logic [3:0] c);
    is_disp = (c == CMD_DISP_A) || (c == CMD_DISP_B) ||
              (c == CMD_DISP_A_KEY) || (c == CMD_DISP_B_KEY);
  endfunction : is_disp

  // True when the code asks for key output
  function automatic logic is_key(input logic [3:0] c);
    is_key = (c[3:1] == CMD_KEY_0) || (c[3:1] == CMD_KEY_1) ||
             (c[3:1] == CMD_KEY_2) || (c == CMD_DISP_A_KEY) ||
             (c == CMD_DISP_B_KEY);
  endfunction : is_key

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  pscp_pins_type pins_raw; // Asynchronous pin group
  pscp_pins_type sync1_reg; // First stage, read only by stage two
  pscp_pins_type sync2_reg; // Safe copy
  pscp_pins_type last_reg; // Previous safe copy, for edges

  assign pins_raw = '{sclk: sclk_in, load: load_in, data: data_in,
                      blank: blank_in};

  // Two stages per pin, then one more for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      last_reg <= '0;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
    end
  end

  // Edge stage resets to the idle low level of both pins, so
  // releasing reset cannot fake a clock or strobe edge
  wire sclk_rise = sync2_reg.sclk & ~last_reg.sclk;
  wire load_rise = sync2_reg.load & ~last_reg.load;

  // ---------------------------------------------------------------
  // State declarations
  // ---------------------------------------------------------------
  // Segment patterns sit apart from the shifter, so a half-sent
  // frame never reaches the pins
  pscp_mode_type mode_reg; // Input or output status
  logic [FRAME_A_BITS-1:0] shift_reg; // Incoming bit history
  logic [SEG_BITS-1:0] frame_a_reg; // Frame A segments
  logic [SEG_BITS-1:0] frame_b_reg; // Frame B segments
  logic led_reg; // Lamp bit from frame A
  logic loaded_reg; // Some display data taken
  logic [KEY_BITS-1:0] key_sh_reg; // Key bits being sent
  logic [KEY_BITS-1:0] keys_reg; // Key states from software
  logic [3:0] cmd_reg; // Last command accepted
  logic [7:0] scan_cnt_reg; // Scan progress
  logic scanning_reg; // Scan running
  logic done_reg; // Scan finished
  logic busy_reg; // Transfer window open
  logic [12:0] idle_cnt_reg; // Cycles since last serial clock
  logic blank_reg; // Blank level in force
  logic dout_reg; // Data line drive value

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  // Newest four bits are the command; b0 is the last one shifted
  wire [3:0] cmd_code = shift_reg[CMD_BITS-1:0];
  wire cmd_disp = is_disp(cmd_code);
  wire cmd_key = is_key(cmd_code);
  wire frame_is_b = cmd_code[0]; // Odd display codes pick frame B
  // Key read before any display is refused as well as unknown codes
  wire take_disp = load_rise && (mode_reg == ST_INPUT) && cmd_disp;
  wire take_key = load_rise && (mode_reg == ST_INPUT) && cmd_key &&
                  (loaded_reg || cmd_disp);
  wire leave_out = load_rise && (mode_reg == ST_OUTPUT);
  wire [SEG_BITS-1:0] seg_field_a = shift_reg[SEG_LSB +: SEG_BITS];
  wire [SEG_BITS-1:0] seg_field_b = shift_reg[SEGB_LSB +: SEG_BITS];

  // ---------------------------------------------------------------
  // Shifter and status sequencing
  // ---------------------------------------------------------------
  // Input shifts on clock rise, output mode sends key bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= ST_INPUT;
      shift_reg <= '0;
      key_sh_reg <= '0;
      dout_reg <= 1'b0;
    end else begin
      case (mode_reg)
        ST_INPUT: begin
          if (sclk_rise) begin
            shift_reg <= {shift_reg[FRAME_A_BITS-2:0], sync2_reg.data};
          end
          // Key bits frozen at entry; writes mid-read cannot tear
          if (take_key) begin
            mode_reg <= ST_OUTPUT;
            key_sh_reg <= keys_reg;
          end
        end
        ST_OUTPUT: begin
          if (leave_out) begin
            mode_reg <= ST_INPUT;
          end else if (sclk_rise) begin
            // Most significant key first, one bit per rise
            dout_reg <= key_sh_reg[KEY_BITS-1];
            key_sh_reg <= {key_sh_reg[KEY_BITS-2:0], 1'b0};
          end
        end
        default: begin
          mode_reg <= ST_INPUT;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Display latches
  // ---------------------------------------------------------------
  // Only the addressed frame changes; the other keeps its pattern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_a_reg <= '0;
      frame_b_reg <= '0;
      led_reg <= 1'b0;
      loaded_reg <= 1'b0;
      cmd_reg <= '0;
    end else if (take_disp) begin
      loaded_reg <= 1'b1;
      cmd_reg <= cmd_code;
      if (frame_is_b) begin
        frame_b_reg <= seg_field_b;
      end else begin
        frame_a_reg <= seg_field_a;
        led_reg <= shift_reg[LED_POS];
      end
    end else if (take_key) begin
      cmd_reg <= cmd_code;
    end
  end

  // ---------------------------------------------------------------
  // Key scan
  // ---------------------------------------------------------------
  // Scan is a fixed delay here; the matrix itself lives elsewhere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scanning_reg <= 1'b0;
      scan_cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      // A new key command restarts the scan from zero
      if (take_key) begin
        scanning_reg <= 1'b1;
        scan_cnt_reg <= '0;
      end else if (scanning_reg) begin
        if (scan_cnt_reg == 8'(SCAN_LEN - 1)) begin
          scanning_reg <= 1'b0;
        end else begin
          scan_cnt_reg <= scan_cnt_reg + 8'h01;
        end
      end
      // Completion beats a strobe in the same cycle, except a strobe that takes a new key command
      if (scanning_reg && !take_key &&
          scan_cnt_reg == 8'(SCAN_LEN - 1)) begin
        done_reg <= 1'b1;
      end else if (load_rise) begin
        done_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Blank window
  // ---------------------------------------------------------------
  // Window opens on serial clock and closes on strobe or long idle,
  // so a stalled master cannot hold the blank level forever
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      idle_cnt_reg <= '0;
      blank_reg <= 1'b1;
    end else begin
      if (load_rise) begin
        busy_reg <= 1'b0;
      end else if (sclk_rise) begin
        busy_reg <= 1'b1;
      end else if (idle_cnt_reg == 13'(BLANK_CYC - 1)) begin
        busy_reg <= 1'b0;
      end
      // Idle counter runs only inside an open window
      if (sclk_rise || !busy_reg) begin
        idle_cnt_reg <= '0;
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 13'h0001;
      end
      // Pending level applied once the window is closed
      if (!busy_reg) begin
        blank_reg <= sync2_reg.blank;
      end
    end
  end

  // ---------------------------------------------------------------
  // Display outputs
  // ---------------------------------------------------------------
  // Nothing lights before the first frame, whatever the blank pin
  wire show = loaded_reg & ~blank_reg;

  // Registered drive; a set bit lights its element
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_a_out <= '0;
      seg_b_out <= '0;
      led_bit <= 1'b0;
      lcd_on <= 1'b0;
    end else begin
      seg_a_out <= show ? frame_a_reg : '0;
      seg_b_out <= show ? frame_b_reg : '0;
      led_bit <= show & led_reg;
      lcd_on <= show;
    end
  end

  // Enable follows the mode flop, so the line is free in input
  // status and the master never fights the device
  assign scan_done = done_reg;
  assign data_out = dout_reg;
  assign data_oe = (mode_reg == ST_OUTPUT);

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Zero wait states, so every access completes in its first access
  wire acc = psel & penable;
  wire hit_keys = (paddr == REG_KEYS);
  wire hit_stat = (paddr == REG_STATUS);
  wire hit_alo = (paddr == REG_SEGA_LO);
  wire hit_ahi = (paddr == REG_SEGA_HI);
  wire hit_blo = (paddr == REG_SEGB_LO);
  wire hit_bhi = (paddr == REG_SEGB_HI);
  // Any one of the six words
  wire mapped = hit_keys | hit_stat | hit_alo | hit_ahi | hit_blo |
                hit_bhi;
  // Live state packed for software polling
  wire [31:0] stat_word = {16'h0000, 4'h0, cmd_reg, 3'h0, busy_reg,
                           done_reg, lcd_on, loaded_reg,
                           (mode_reg == ST_OUTPUT)};
  wire [31:0] rd_mux = hit_keys ? {2'b00, keys_reg} :
                       hit_stat ? stat_word :
                       hit_alo ? frame_a_reg[31:0] :
                       hit_ahi ? {24'h000000, frame_a_reg[39:32]} :
                       hit_blo ? frame_b_reg[31:0] :
                       hit_bhi ? {24'h000000, frame_b_reg[39:32]} :
                       32'h00000000;

  // Never stalls; an unmapped address is flagged, not hung
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // Key states written by software; read data held in a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keys_reg <= KEYS_RESET;
      prdata <= '0;
    end else begin
      if (acc && pwrite && hit_keys) begin
        keys_reg <= pwdata[KEY_BITS-1:0];
      end
      // Writes return zero so stale read data never leaks back
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

endmodule : pscp_core

// [core/pscp_pkg.sv]
// Shared constants and types of the panel serial command port
package pscp_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int CMD_BITS = 4; // Command field width
  localparam int SEG_BITS = 40; // Segment bits per frame
  localparam int FRAME_A_BITS = 45; // Command, segments and lamp bit
  localparam int FRAME_B_BITS = 44; // Command and segments only
  localparam int KEY_BITS = 30; // One bit per key
  localparam int SEG_LSB = 5; // Frame A segment field starts here
  localparam int LED_POS = 4; // Frame A lamp bit position
  localparam int SEGB_LSB = 4; // Frame B segment field starts here

  // ---------------------------------------------------------------
  // Command codes, b3 down to b0
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_DISP_A = 4'h2; // Load frame A
  localparam logic [3:0] CMD_DISP_B = 4'h3; // Load frame B
  localparam logic [3:0] CMD_DISP_A_KEY = 4'h6; // Frame A plus key read
  localparam logic [3:0] CMD_DISP_B_KEY = 4'h7; // Frame B plus key read
  localparam logic [2:0] CMD_KEY_0 = 3'h2; // 010x key read
  localparam logic [2:0] CMD_KEY_1 = 3'h6; // 110x key read
  localparam logic [2:0] CMD_KEY_2 = 3'h7; // 111x key read

  // ---------------------------------------------------------------
  // Register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_KEYS = 8'h00; // Key states, read/write
  localparam logic [7:0] REG_STATUS = 8'h04; // Port state, read only
  localparam logic [7:0] REG_SEGA_LO = 8'h08; // Frame A bits 31..0
  localparam logic [7:0] REG_SEGA_HI = 8'h0C; // Frame A bits 39..32
  localparam logic [7:0] REG_SEGB_LO = 8'h10; // Frame B bits 31..0
  localparam logic [7:0] REG_SEGB_HI = 8'h14; // Frame B bits 39..32
  localparam logic [29:0] KEYS_RESET = 30'h00000000; // No key pressed

  // Status register field positions
  localparam int ST_OUTPUT_POS = 0; // Output status active
  localparam int ST_LOADED_POS = 1; // Display data seen
  localparam int ST_LCD_ON_POS = 2; // Display driven
  localparam int ST_DONE_POS = 3; // Scan done
  localparam int ST_BUSY_POS = 4; // Transfer window open
  localparam int ST_CMD_LSB = 8; // Last command taken

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000; // System clock rate
  localparam int BLANK_WIN_NS = 50_000; // Blank takes effect within
  // Longest time rounds down
  localparam int BLANK_WIN_CYC = BLANK_WIN_NS / (1_000_000_000 / CLK_HZ);
  localparam int SCAN_CYC = 16; // Length of one key scan

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sclk; // Serial clock from master
    logic load; // Load strobe
    logic data; // Data line level
    logic blank; // Blanking input
  } pscp_pins_type;

  typedef enum logic {ST_INPUT, ST_OUTPUT} pscp_mode_type;

endpackage : pscp_pkg

// [dv/pscp_core_props.sv]
// Concurrent checks on the serial command port pins
`timescale 1ns/100ps
module pscp_core_props #(
  parameter int BLANK_CYC = pscp_pkg::BLANK_WIN_CYC // Window timeout
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sclk_in,
  input wire logic load_in,
  input wire logic blank_in,
  input wire logic data_out,
  input wire logic data_oe,
  input wire logic [pscp_pkg::SEG_BITS-1:0] seg_a_out,
  input wire logic lcd_on,
  input wire logic scan_done
);
  import pscp_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int quiet_cnt; // Cycles of blank high with clock and load pins at rest
  logic map_hit; // Address inside the register map
  assign map_hit = paddr inside {REG_KEYS, REG_STATUS, REG_SEGA_LO,
    REG_SEGA_HI, REG_SEGB_LO, REG_SEGB_HI};
  // Counter saturates so it never wraps during long idle spans
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_cnt <= 0;
    else if (!blank_in || $changed(sclk_in) || $changed(load_in))
      quiet_cnt <= 0;
    else if (quiet_cnt < 4 * BLANK_CYC) quiet_cnt <= quiet_cnt + 1;
  end
  chk_blank_off: assert property (quiet_cnt >= 2 * BLANK_CYC + 8 |-> !lcd_on)
    else $error("display still on while blanked");
  chk_lcd_unblank: assert property ($rose(lcd_on) |-> !blank_in)
    else $error("display lit with blank high");
  chk_oe_enter: assert property ($rose(data_oe) |-> load_in)
    else $error("data line taken without load");
  chk_oe_leave: assert property ($fell(data_oe) |-> load_in)
    else $error("data line freed without load");
  chk_key_clock: assert property (data_oe && $past(data_oe) &&
    $changed(data_out) && !$rose(scan_done) |-> sclk_in)
    else $error("key bit moved off clock rise");
  chk_done_in_out: assert property ($rose(scan_done) |-> data_oe)
    else $error("scan done outside output");
  chk_done_clear: assert property ($fell(scan_done) |-> load_in)
    else $error("scan done cleared without load");
  chk_seg_on_load: assert property ($changed(seg_a_out) |->
    load_in || $changed(lcd_on))
    else $error("segments moved without load");
  chk_apb_unmap: assert property (psel && penable && !map_hit |->
    pslverr && prdata == 32'h00000000)
    else $error("unmapped access not flagged");
  chk_apb_map: assert property (psel && penable && map_hit |->
    pready && !pslverr)
    else $error("mapped access refused");
  cover property ($rose(data_oe));
  cover property ($rose(scan_done));
  cover property ($fell(lcd_on));
endmodule : pscp_core_props

// [dv/pscp_master_model.sv]
// Serial master model driving clock, load and data line
`timescale 1ns/100ps
module pscp_master_model (
  input wire logic pclk,
  input wire logic dev_out,
  input wire logic dev_oe,
  output logic sclk,
  output logic load,
  output logic line
);
  logic drv = 1'b1; // Master owns the line
  logic dat = 1'b0; // Last value put out
  // Released line shows the inverse, never a stale copy
  assign line = dev_oe ? dev_out : (drv ? dat : ~dat);
  initial sclk = 1'b0;
  initial load = 1'b0;
  // First bit first; data moves while the clock is low
  task automatic send(input logic [44:0] v, input int n);
    @(posedge pclk);
    // Four cycles low, four high: one bit per 80 ns
    for (int i = n - 1; i >= 0; i--) begin
      drv <= 1'b1;
      dat <= v[i];
      sclk <= 1'b0;
      repeat (4) @(posedge pclk);
      sclk <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    sclk <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : send
  // Strobe rise acts; quiet time after it for decode
  task automatic pulse();
    @(posedge pclk);
    load <= 1'b1;
    repeat (8) @(posedge pclk);
    load <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : pulse
  // Clock one key bit out with the line released
  task automatic rd_bit(output logic b);
    @(posedge pclk);
    drv <= 1'b0;
    sclk <= 1'b1;
    // Bit settles three cycles after the rise; take it at the fall
    repeat (4) @(posedge pclk);
    b = line;
    sclk <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : rd_bit
endmodule : pscp_master_model

// [dv/test_panel_serial_command_port.sv]
// Self-checking bench of the serial command port
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module test_panel_serial_command_port;
  import pscp_pkg::*;
  localparam int BLANK_CYC = 50; // Short window for simulation
  localparam logic [39:0] SEG_A = 40'hA50F3C9617; // Frame A pattern
  localparam logic [39:0] SEG_A2 = 40'h3C5AF0E1D2; // Must not land
  localparam logic [39:0] SEG_B = 40'h5A3C69E187 & ~40'h1084210000;
  localparam logic [29:0] KEYS = 30'h2B4D1E96; // Pressed keys
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, blank_in = 1'b0, err, b;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, sclk, load, line, data_out, data_oe;
  logic [39:0] seg_a_out, seg_b_out;
  logic led_bit, lcd_on, scan_done;
  int fails = 0, cmp_count = 0;
  always #5 pclk = ~pclk;
  pscp_core #(.BLANK_CYC(BLANK_CYC), .SCAN_LEN(SCAN_CYC)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclk_in(sclk), .load_in(load),
    .data_in(line), .data_out(data_out), .data_oe(data_oe),
    .blank_in(blank_in), .seg_a_out(seg_a_out), .seg_b_out(seg_b_out),
    .led_bit(led_bit), .lcd_on(lcd_on), .scan_done(scan_done));
  pscp_master_model u_mst (.pclk(pclk), .dev_out(data_out),
    .dev_oe(data_oe), .sclk(sclk), .load(load), .line(line));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // APB transfer; waits on pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic t_reset();
    `CHK(lcd_on, 1'b0)
    `CHK(seg_a_out, 40'h0)
    `CHK(data_oe, 1'b0)
    apb(1'b0, REG_KEYS, 32'h0);
    `CHK(rd[29:0], KEYS_RESET)
    u_mst.send(45'h4, 4);
    u_mst.pulse();
    `CHK(data_oe, 1'b0)
    $display("reset and early load test done");
  endtask : t_reset
  // Display load, then every prohibited code must leave it alone
  task automatic t_frame_a();
    logic [23:0] bad;
    bad = 24'h0189AB;
    u_mst.send({SEG_A, 1'b1, CMD_DISP_A}, 45);
    u_mst.pulse();
    `CHK(seg_a_out, SEG_A)
    `CHK(led_bit, 1'b1)
    `CHK(lcd_on, 1'b1)
    apb(1'b0, REG_SEGA_LO, 32'h0);
    `CHK(rd, SEG_A[31:0])
    for (int i = 0; i < 6; i++) begin
      u_mst.send({SEG_A2, 1'b0, bad[4*i +: 4]}, 45);
      u_mst.pulse();
      `CHK(seg_a_out, SEG_A)
      `CHK(data_oe, 1'b0)
    end
    apb(1'b1, REG_STATUS, 32'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[ST_LOADED_POS], 1'b1)
    apb(1'b0, 8'h20, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("frame A test done");
  endtask : t_frame_a
  // Blank off, frame B while blanked, blank drop mid transfer
  task automatic t_blank();
    blank_in <= 1'b1;
    for (int i = 0; i < BLANK_CYC + 30 && lcd_on !== 1'b0; i++)
      @(posedge pclk);
    `CHK(lcd_on, 1'b0)
    repeat (2 * BLANK_CYC + 20) @(posedge pclk);
    `CHK(lcd_on, 1'b0)
    u_mst.send({1'b0, SEG_B, CMD_DISP_B}, 44);
    u_mst.pulse();
    fork
      u_mst.send({SEG_A, 1'b1, CMD_DISP_A}, 45);
      begin
        repeat (60) @(posedge pclk);
        blank_in <= 1'b0;
      end
    join
    `CHK(lcd_on, 1'b0)
    u_mst.pulse();
    for (int i = 0; i < BLANK_CYC + 30 && lcd_on !== 1'b1; i++)
      @(posedge pclk);
    `CHK(lcd_on, 1'b1)
    `CHK(seg_b_out, SEG_B)
    // Stalled partial frame: idle timeout must close the window
    u_mst.send(45'h0, 4);
    blank_in <= 1'b1;
    for (int i = 0; i < 2 * BLANK_CYC + 30 && lcd_on !== 1'b0; i++)
      @(posedge pclk);
    `CHK(lcd_on, 1'b0)
    u_mst.pulse();
    blank_in <= 1'b0;
    $display("blank test done");
  endtask : t_blank
  // Key read after display load, then each key code in turn
  task automatic t_key();
    logic [27:0] kc;
    kc = 28'h5CDEF67;
    apb(1'b1, REG_KEYS, {2'b00, KEYS});
    u_mst.send(45'h4, 4);
    u_mst.pulse();
    `CHK(data_oe, 1'b1)
    for (int i = 0; i < SCAN_CYC + 30 && scan_done !== 1'b1; i++)
      @(posedge pclk);
    `CHK(scan_done, 1'b1)
    for (int i = 29; i >= 0; i--) begin
      u_mst.rd_bit(b);
      `CHK(b, KEYS[i])
    end
    u_mst.pulse();
    `CHK({data_oe, scan_done}, 2'b00)
    for (int i = 0; i < 7; i++) begin
      u_mst.send({SEG_A, 1'b1, kc[4*i +: 4]}, 45);
      u_mst.pulse();
      `CHK(data_oe, 1'b1)
      for (int j = 0; j < SCAN_CYC + 30 && scan_done !== 1'b1; j++)
        @(posedge pclk);
      `CHK(scan_done, 1'b1)
      u_mst.pulse();
      `CHK(data_oe, 1'b0)
    end
    $display("key read test done");
  endtask : t_key
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_frame_a();
    t_blank();
    t_key();
    report_and_stop();
  end
  // Watchdog, well past the expected run length
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    report_and_stop();
  end
endmodule : test_panel_serial_command_port
bind pscp_core pscp_core_props #(.BLANK_CYC(BLANK_CYC)) u_props (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr),
  .sclk_in(sclk_in), .load_in(load_in), .blank_in(blank_in),
  .data_out(data_out), .data_oe(data_oe), .seg_a_out(seg_a_out),
  .lcd_on(lcd_on), .scan_done(scan_done));
